// ---- verilog/ssx_pkg.sv ----
// shared constants and carrier types for the serial transmit channel
package ssx_pkg;

  // widest character the channel serves
  localparam int MAX_CHAR_LEN = 9;
  // shortest character length the channel and shifter accept
  localparam int MIN_CHAR_LEN = 3;
  // default character length and its sync pattern, bit 0 goes out first
  localparam int DEF_CHAR_LEN = 9;
  localparam logic [MAX_CHAR_LEN-1:0] DEF_SYNC_CHAR = 9'h0d3;

  // reset values of the control flags
  localparam logic RST_FLAG = 1'b0;
  // line level while the channel is quiet
  localparam logic MARK_LEVEL = 1'b1;

  // pin synchroniser depth; the stage pair that must agree is fixed in ssx_pin_sync
  localparam int SYNC_DEPTH = 3;

  // pin indices inside the synchronised pin vector
  localparam int PIN_TIMING = 0;
  localparam int PIN_CTS = 1;
  localparam int PIN_COUNT = 2;

  // one-cycle instruction strobes from the host, with the data lines
  typedef struct packed {
    logic load_tx_char_instr;
    logic set_idle_instr;
    logic clear_idle_instr;
    logic clear_txflag_instr;
    logic skip_on_txflag_instr;
    logic [MAX_CHAR_LEN-1:0] data;
  } ssx_host_cmd_t;

  // answers towards the host
  typedef struct packed {
    logic interrupt_request_gate;
    logic skip;
  } ssx_host_rsp_t;

  // lines towards the data set
  typedef struct packed {
    logic serial_out_bit;
    logic rts;
  } ssx_modem_out_t;

  // channel state visible to the host side
  typedef struct packed {
    logic tx_active_flag;
    logic char_pending;
    logic tx_request_flag;
    logic idle_mode;
    logic send_req;
  } ssx_status_t;

endpackage : ssx_pkg

// ---- verilog/ssx_pin_sync.sv ----
// three-stage synchroniser with agreement filter and rising-edge pulse
module ssx_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("ssx_pin_sync: WIDTH must be at least 1");
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic [ssx_pkg::SYNC_DEPTH-1:0] stage_ff;
      logic [ssx_pkg::SYNC_DEPTH-1:0] nxt_stage;
      logic level_ff;
      logic nxt_level;
      logic rise_ff;
      logic nxt_rise;

      // the first stage only feeds the second; stages 2 and 3 must agree
      always_comb begin
        nxt_stage = {stage_ff[ssx_pkg::SYNC_DEPTH-2:0], pin_in[gi]};
        nxt_level = level_ff;
        nxt_rise = 1'b0;
        if (stage_ff[1] == stage_ff[2]) begin
          nxt_level = stage_ff[2];
          nxt_rise = stage_ff[2] & ~level_ff;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_ff <= '0;
          level_ff <= 1'b0;
          rise_ff <= 1'b0;
        end else begin
          stage_ff <= nxt_stage;
          level_ff <= nxt_level;
          rise_ff <= nxt_rise;
        end
      end

      assign level_out[gi] = level_ff;
      assign rise_out[gi] = rise_ff;
    end
  endgenerate

endmodule : ssx_pin_sync

// ---- verilog/ssx_shifter.sv ----
// transmit shift register with end marker and last-bit detector
module ssx_shifter #(
  parameter int CHAR_LEN = ssx_pkg::DEF_CHAR_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift_reg_load_pulse,
  input wire logic tx_shift_pulse,
  input wire logic [CHAR_LEN-1:0] load_data,
  output logic shift_stage_one,
  output logic last_bit
);

  initial begin
    if (CHAR_LEN < ssx_pkg::MIN_CHAR_LEN || CHAR_LEN > ssx_pkg::MAX_CHAR_LEN) begin
      $error("ssx_shifter: CHAR_LEN out of range");
    end
  end

  // index 0 is the first stage, index CHAR_LEN is the end marker
  logic [CHAR_LEN:0] tx_shift_reg_ff;
  logic [CHAR_LEN:0] nxt_tx_shift_reg;

  always_comb begin
    nxt_tx_shift_reg = tx_shift_reg_ff;
    if (shift_reg_load_pulse) begin
      nxt_tx_shift_reg = {1'b1, load_data};
    end else if (tx_shift_pulse) begin
      nxt_tx_shift_reg = {1'b0, tx_shift_reg_ff[CHAR_LEN:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_reg_ff <= '0;
    end else begin
      tx_shift_reg_ff <= nxt_tx_shift_reg;
    end
  end

  assign shift_stage_one = tx_shift_reg_ff[0];
  // stages three up and marker clear; also true after reset
  assign last_bit = ~|tx_shift_reg_ff[CHAR_LEN:2];

endmodule : ssx_shifter

// ---- verilog/ssx_tx_channel.sv ----
// transmit channel of the bit-synchronous serial adapter
//
// the data set's transmit timing and clear-to-send arrive as pins and are
// sampled on clk; every rising edge of timing is one timing pulse, and a
// timing pulse seen while clear-to-send is on is one transmit clock pulse.

// Behaviour
// - only a loaded sync character starts transmit-active mode
// - when active, one bit goes out per transmit clock pulse
// - no character in normal mode: stop and hold the line at mark
// - no character in idle mode: resend the last character
// - reset clears send request and active, no shifts, line at mark
// - host sets and clears idle mode; clear-idle ends retransmission
// - load instruction strobes data into buffer, sets pending flag
// - sync load sets send-request and active; next timing pulse raises RTS
// - timing pulses become transmit clock only while clear-to-send is on
// - non-sync load while not active clears send-request; next timing pulse drops RTS
// - empty register at last bit: clock pulse loads instead of shifting
// - load into shifter sets transmit flag, clears pending; flag interrupts
// - skip test on transmit flag gives no skip while flag is set
// - timely load stores character, sets pending, clears transmit flag
// - shifts move toward stage one, which drives serial data
// - last bit blocks shifting, triggers load and a new interrupt
// - missed character, normal mode: no shift or load, end transmission
// - afterwards stay quiet until another sync character is loaded
// - missed character, idle mode: reload previous character repeatedly
// - each load sets the end marker; shifts move it and fill zero
// - last bit when stages three up and marker are all zero
// - shifter length follows character length; sync checked at each load
module ssx_tx_channel #(
  parameter int CHAR_LEN = ssx_pkg::DEF_CHAR_LEN,
  parameter logic [ssx_pkg::MAX_CHAR_LEN-1:0] SYNC_CHAR = ssx_pkg::DEF_SYNC_CHAR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ssx_pkg::ssx_host_cmd_t host_cmd,
  output ssx_pkg::ssx_host_rsp_t host_rsp,
  input wire logic tx_timing_pin,
  input wire logic cts_pin,
  output ssx_pkg::ssx_modem_out_t modem_out,
  output ssx_pkg::ssx_status_t status
);

  initial begin
    if (CHAR_LEN < ssx_pkg::MIN_CHAR_LEN || CHAR_LEN > ssx_pkg::MAX_CHAR_LEN) begin
      $error("ssx_tx_channel: CHAR_LEN out of range");
    end
  end

  // ---------------------------------------------------------------- pins
  logic [ssx_pkg::PIN_COUNT-1:0] pin_raw;
  logic [ssx_pkg::PIN_COUNT-1:0] pin_level;
  logic [ssx_pkg::PIN_COUNT-1:0] pin_rise;
  logic timing_pulse;
  logic cts_level;
  logic tx_clock_pulse;

  always_comb begin
    pin_raw = '0;
    pin_raw[ssx_pkg::PIN_TIMING] = tx_timing_pin;
    pin_raw[ssx_pkg::PIN_CTS] = cts_pin;
  end

  ssx_pin_sync #(
    .WIDTH(ssx_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(pin_raw),
    .level_out(pin_level),
    .rise_out(pin_rise)
  );

  assign timing_pulse = pin_rise[ssx_pkg::PIN_TIMING];
  assign cts_level = pin_level[ssx_pkg::PIN_CTS];
  assign tx_clock_pulse = timing_pulse & cts_level;

  // ------------------------------------------------------------- buffer
  logic [CHAR_LEN-1:0] tx_holding_buffer_ff;
  logic [CHAR_LEN-1:0] nxt_tx_holding_buffer;
  logic holding_load_strobe;
  logic is_sync_char;

  assign holding_load_strobe = host_cmd.load_tx_char_instr;
  // sync compare on the loaded character
  assign is_sync_char = (host_cmd.data[CHAR_LEN-1:0] == SYNC_CHAR[CHAR_LEN-1:0]);

  always_comb begin
    nxt_tx_holding_buffer = tx_holding_buffer_ff;
    if (holding_load_strobe) begin
      nxt_tx_holding_buffer = host_cmd.data[CHAR_LEN-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_buffer_ff <= '0;
    end else begin
      tx_holding_buffer_ff <= nxt_tx_holding_buffer;
    end
  end

  // ------------------------------------------------------------ shifter
  logic shift_reg_load_pulse;
  logic tx_shift_pulse;
  logic shift_stage_one;
  logic last_bit;

  ssx_shifter #(
    .CHAR_LEN(CHAR_LEN)
  ) u_shifter (
    .clk(clk),
    .rst_n(rst_n),
    .shift_reg_load_pulse(shift_reg_load_pulse),
    .tx_shift_pulse(tx_shift_pulse),
    .load_data(tx_holding_buffer_ff),
    .shift_stage_one(shift_stage_one),
    .last_bit(last_bit)
  );

  // ------------------------------------------------------- control flags
  logic tx_active_flag_ff;
  logic nxt_tx_active_flag;
  logic send_req_ff;
  logic nxt_send_req;
  logic rts_drive_flag_ff;
  logic nxt_rts_drive_flag;
  logic char_pending_ff;
  logic nxt_char_pending;
  logic tx_request_flag_ff;
  logic nxt_tx_request_flag;
  logic idle_mode_ff;
  logic nxt_idle_mode;
  logic msg_end;
  logic skip_ff;
  logic nxt_skip;

  // a clock pulse at the last bit either reloads or ends the message
  always_comb begin
    shift_reg_load_pulse = 1'b0;
    tx_shift_pulse = 1'b0;
    msg_end = 1'b0;
    if (tx_active_flag_ff && tx_clock_pulse) begin
      if (!last_bit) begin
        tx_shift_pulse = 1'b1;
      end else if (char_pending_ff || idle_mode_ff) begin
        shift_reg_load_pulse = 1'b1;
      end else begin
        msg_end = 1'b1;
      end
    end
  end

  always_comb begin
    nxt_tx_active_flag = tx_active_flag_ff;
    nxt_send_req = send_req_ff;
    nxt_rts_drive_flag = rts_drive_flag_ff;
    nxt_idle_mode = idle_mode_ff;

    // timing pulse copies send request to RTS
    // and drops it once the request is gone
    if (timing_pulse) begin
      nxt_rts_drive_flag = send_req_ff;
    end

    // end clears active, send request and RTS
    // quiet until the next sync load
    if (msg_end) begin
      nxt_tx_active_flag = 1'b0;
      nxt_send_req = 1'b0;
      nxt_rts_drive_flag = 1'b0;
    end

    // a non-sync data load during a running message must not drop RTS,
    // so the send-request clear applies only while not active
    if (holding_load_strobe) begin
      if (is_sync_char) begin
        nxt_send_req = 1'b1;
        nxt_tx_active_flag = 1'b1;
      end else if (!tx_active_flag_ff) begin
        nxt_send_req = 1'b0;
      end
    end

    // idle set and clear by host
    if (host_cmd.clear_idle_instr) begin
      nxt_idle_mode = 1'b0;
    end else if (host_cmd.set_idle_instr) begin
      nxt_idle_mode = 1'b1;
    end
  end

  // set wins over clear on both handshake flags
  always_comb begin
    nxt_char_pending = char_pending_ff;
    nxt_tx_request_flag = tx_request_flag_ff;
    if (shift_reg_load_pulse) begin
      nxt_char_pending = 1'b0;
    end
    if (holding_load_strobe) begin
      nxt_char_pending = 1'b1;
    end
    if (holding_load_strobe || host_cmd.clear_txflag_instr) begin
      nxt_tx_request_flag = 1'b0;
    end
    if (shift_reg_load_pulse) begin
      nxt_tx_request_flag = 1'b1;
    end
  end

  // skip only while the flag is clear
  always_comb begin
    nxt_skip = host_cmd.skip_on_txflag_instr & ~tx_request_flag_ff;
  end

  // reset clears flags, line at mark
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_active_flag_ff <= ssx_pkg::RST_FLAG;
      send_req_ff <= ssx_pkg::RST_FLAG;
      rts_drive_flag_ff <= ssx_pkg::RST_FLAG;
      char_pending_ff <= ssx_pkg::RST_FLAG;
      tx_request_flag_ff <= ssx_pkg::RST_FLAG;
      idle_mode_ff <= ssx_pkg::RST_FLAG;
      skip_ff <= ssx_pkg::RST_FLAG;
    end else begin
      tx_active_flag_ff <= nxt_tx_active_flag;
      send_req_ff <= nxt_send_req;
      rts_drive_flag_ff <= nxt_rts_drive_flag;
      char_pending_ff <= nxt_char_pending;
      tx_request_flag_ff <= nxt_tx_request_flag;
      idle_mode_ff <= nxt_idle_mode;
      skip_ff <= nxt_skip;
    end
  end

  // ------------------------------------------------------------ outputs
  logic serial_out_bit;

  assign serial_out_bit = tx_active_flag_ff ? shift_stage_one : ssx_pkg::MARK_LEVEL;

  always_comb begin
    modem_out.serial_out_bit = serial_out_bit;
    modem_out.rts = rts_drive_flag_ff;
    host_rsp.interrupt_request_gate = tx_request_flag_ff;
    host_rsp.skip = skip_ff;
    status.tx_active_flag = tx_active_flag_ff;
    status.char_pending = char_pending_ff;
    status.tx_request_flag = tx_request_flag_ff;
    status.idle_mode = idle_mode_ff;
    status.send_req = send_req_ff;
  end

endmodule : ssx_tx_channel

// ---- bench/ssx_tx_channel_props.sv ----
// port checks for the serial transmit channel
module ssx_tx_props #(
  parameter int CHAR_LEN = ssx_pkg::DEF_CHAR_LEN,
  parameter logic [ssx_pkg::MAX_CHAR_LEN-1:0] SYNC_CHAR = ssx_pkg::DEF_SYNC_CHAR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ssx_pkg::ssx_host_cmd_t host_cmd,
  input wire ssx_pkg::ssx_host_rsp_t host_rsp,
  input wire logic tx_timing_pin,
  input wire logic cts_pin,
  input wire ssx_pkg::ssx_modem_out_t modem_out,
  input wire ssx_pkg::ssx_status_t status
);
  logic [3:0] cts_low_ff;
  logic [3:0] nxt_cts_low;
  logic ld;
  logic syn;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  assign ld = host_cmd.load_tx_char_instr;
  assign syn = host_cmd.data[CHAR_LEN-1:0] == SYNC_CHAR[CHAR_LEN-1:0];
  // cts must stay off past the pin filter before shifts are surely blocked
  always_comb begin
    nxt_cts_low = cts_low_ff;
    if (cts_pin) nxt_cts_low = 4'h0;
    else if (cts_low_ff != 4'hf) nxt_cts_low = cts_low_ff + 4'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cts_low_ff <= 4'h0;
    else cts_low_ff <= nxt_cts_low;
  end
  AST_LOAD_PEND: assert property (ld |=> status.char_pending)
    else $error("load left pending clear");
  AST_SYNC_GO: assert property (ld && syn && !status.tx_active_flag
    |=> status.tx_active_flag && status.send_req) else $error("sync load did not start");
  AST_NOSYNC: assert property (ld && !syn && !status.tx_active_flag
    |=> !status.tx_active_flag && !status.send_req) else $error("plain load started");
  AST_IDLE_CLR: assert property (host_cmd.clear_idle_instr |=> !status.idle_mode)
    else $error("idle not cleared");
  AST_SKIP: assert property (host_cmd.skip_on_txflag_instr
    |=> host_rsp.skip == !$past(status.tx_request_flag)) else $error("skip wrong");
  // only a shifter load raises the flag, and that needs an active channel
  AST_IRQ: assert property ($rose(status.tx_request_flag)
    |-> host_rsp.interrupt_request_gate && $past(status.tx_active_flag))
    else $error("interrupt missing or raised while inactive");
  AST_PEND_DROP: assert property ($rose(status.tx_request_flag) && !$past(ld)
    |-> !status.char_pending) else $error("pending kept");
  AST_MARK: assert property (!status.tx_active_flag && !$past(status.tx_active_flag)
    |-> modem_out.serial_out_bit == ssx_pkg::MARK_LEVEL) else $error("line not at mark");
  AST_RTS_SRC: assert property ($rose(modem_out.rts) |-> $past(status.send_req))
    else $error("rts without send request");
  AST_CTS_GATE: assert property (cts_low_ff > 4'h9 && status.tx_active_flag
    && $past(status.tx_active_flag) |-> $stable(modem_out.serial_out_bit))
    else $error("shift without cts");
  AST_END: assert property ($fell(status.tx_active_flag) |-> ##[0:1]
    !modem_out.rts && !status.send_req) else $error("end left rts on");
  cover property (status.tx_active_flag && modem_out.rts && cts_pin);
  cover property ($rose(host_rsp.interrupt_request_gate) && status.idle_mode);
  cover property (host_cmd.skip_on_txflag_instr && status.tx_request_flag);
endmodule : ssx_tx_props

bind ssx_tx_channel ssx_tx_props #(.CHAR_LEN(CHAR_LEN), .SYNC_CHAR(SYNC_CHAR)) u_ssx_tx_props (
  .clk(clk), .rst_n(rst_n), .host_cmd(host_cmd), .host_rsp(host_rsp),
  .tx_timing_pin(tx_timing_pin), .cts_pin(cts_pin), .modem_out(modem_out), .status(status));

// ---- bench/ssx_modem_model.sv ----
// data set model: transmit timing and clear-to-send
module ssx_modem_model #(
  parameter int HALF_NS = 24,
  parameter int CTS_DLY_NS = 100
) (
  input wire logic rts,
  output logic tx_timing_pin,
  output logic cts_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial tx_timing_pin = 1'h0;
  initial cts_pin = 1'h0;
  always #(HALF_NS) tx_timing_pin = ~tx_timing_pin;
  always @(rts) cts_pin <= #(CTS_DLY_NS) rts;
endmodule : ssx_modem_model

// ---- bench/tb.sv ----
// self-checking bench for the serial transmit channel
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CL = ssx_pkg::DEF_CHAR_LEN;
  localparam logic [8:0] SYNC = ssx_pkg::DEF_SYNC_CHAR;
  localparam int LD = 13;
  localparam int SI = 12;
  localparam int CI = 11;
  localparam int CF = 10;
  localparam int SK = 9;
  localparam int ACT = 2;
  localparam int RTS = 1;
  localparam int IRQ = 0;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  ssx_pkg::ssx_host_cmd_t host_cmd = '0;
  ssx_pkg::ssx_host_rsp_t host_rsp;
  ssx_pkg::ssx_modem_out_t modem_out;
  ssx_pkg::ssx_status_t status;
  logic tx_timing_pin;
  logic cts_pin;
  logic [2:0] mon;
  int errors = 0;
  int total_checks = 0;

  ssx_tx_channel u_ssx_tx_channel (.clk(clk), .rst_n(rst_n), .host_cmd(host_cmd),
    .host_rsp(host_rsp), .tx_timing_pin(tx_timing_pin), .cts_pin(cts_pin),
    .modem_out(modem_out), .status(status));
  ssx_modem_model u_ssx_modem_model (.rts(modem_out.rts), .tx_timing_pin(tx_timing_pin),
    .cts_pin(cts_pin));

  assign mon = {status.tx_active_flag, modem_out.rts, host_rsp.interrupt_request_gate};
  always #2.5 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one strobe for one cycle, all changes on the falling edge
  task automatic cmd(input int b, input logic [8:0] d);
    ssx_pkg::ssx_host_cmd_t c;
    c = '0;
    c.data = d;
    c[b] = 1'h1;
    @(negedge clk);
    host_cmd = c;
    @(negedge clk);
    host_cmd = '0;
  endtask : cmd

  task automatic waitm(input int i, input logic v);
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mon[i] !== v && n < 400);
    if (mon[i] !== v) begin
      errors++;
      $display("FAIL wait line %0d expected %h seen %h", i, v, mon[i]);
      summarize();
    end
  endtask : waitm

  // the line is sampled just before each timing edge takes effect
  task automatic frame(input string nm, input logic [8:0] exp);
    logic [8:0] got;
    got = '0;
    for (int i = 0; i < CL; i++) begin
      @(posedge tx_timing_pin);
      got[i] = modem_out.serial_out_bit;
    end
    chk(nm, exp, got);
  endtask : frame

  initial begin
    #20us;
    errors++;
    $display("FAIL watchdog expected done seen running");
    summarize();
  end

  initial begin
    repeat (5) @(negedge clk);
    chk("reset status", 9'h0, {4'h0, status});
    chk("reset line", 9'h2, {7'h0, modem_out});
    rst_n = 1'h1;
    cmd(LD, 9'h055);
    chk("plain load", 9'h8, {4'h0, status});
    cmd(SK, 9'h0);
    chk("skip clear", 9'h1, {7'h0, host_rsp});
    repeat (30) @(negedge clk);
    chk("plain rts", 9'h2, {7'h0, modem_out});
    $display("test plain load done");
    cmd(LD, SYNC);
    chk("sync status", 9'h19, {4'h0, status});
    waitm(RTS, 1'h1);
    waitm(IRQ, 1'h1);
    chk("first load", 9'h15, {4'h0, status});
    // the host keeps pace: next character before the next transmit clock
    cmd(LD, 9'h0a5);
    chk("timely load", 9'h19, {4'h0, status});
    frame("sync bits", SYNC);
    frame("data bits", 9'h0a5);
    waitm(ACT, 1'h0);
    repeat (40) @(negedge clk);
    chk("end line", 9'h2, {7'h0, modem_out});
    chk("end status", 9'h4, {4'h0, status});
    cmd(SK, 9'h0);
    chk("skip set", 9'h2, {7'h0, host_rsp});
    cmd(CF, 9'h0);
    chk("flag clear", 9'h0, {7'h0, host_rsp});
    $display("test normal message done");
    cmd(SI, 9'h0);
    chk("idle set", 9'h2, {4'h0, status});
    cmd(LD, SYNC);
    waitm(IRQ, 1'h1);
    cmd(LD, 9'h136);
    frame("idle sync", SYNC);
    frame("idle data", 9'h136);
    frame("idle repeat", 9'h136);
    frame("idle repeat 2", 9'h136);
    cmd(CI, 9'h0);
    waitm(ACT, 1'h0);
    chk("idle end line", 9'h2, {7'h0, modem_out});
    $display("test idle mode done");
    cmd(LD, SYNC);
    waitm(RTS, 1'h1);
    rst_n = 1'h0;
    @(negedge clk);
    chk("mid reset line", 9'h2, {7'h0, modem_out});
    chk("mid reset status", 9'h0, {4'h0, status});
    rst_n = 1'h1;
    // clear-to-send is still on here; the channel must stay quiet anyway
    repeat (2) @(negedge clk);
    chk("after reset status", 9'h0, {4'h0, status});
    chk("after reset line", 9'h2, {7'h0, modem_out});
    $display("test mid reset done");
    summarize();
  end
endmodule : tb
